// *** bench/usi_master_model.sv ***
/*
  Behavioural two-wire bus master that makes the serial clock by toggling open-drain pulls.
  Assumes pull-ups on both lines and the resolved line levels fed back on scl_i and sda_i.
*/
`timescale 1ns/1ps
module usi_master_model (
  input wire logic clk_sys_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic stuck_o
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    stuck_o = 1'b0;
  end

  task automatic half_bit();
    repeat (8) @(posedge clk_sys_i);
    #1;
  endtask

  // A slave may stretch the clock, so the wait for a high line is bounded and flagged.
  task automatic release_scl();
    int n;
    n = 0;
    scl_oe_o = 1'b0;
    while (scl_i !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
    if (n >= 2000) begin
      stuck_o = 1'b1;
    end
  endtask

  // The clock stays high well past the detector's data line delay.
  task automatic start_cond();
    sda_oe_o = 1'b1;
    repeat (3) half_bit();
    scl_oe_o = 1'b1;
    half_bit();
  endtask

  task automatic clock_bit(input logic b, output logic s);
    sda_oe_o = ~b;
    half_bit();
    release_scl();
    half_bit();
    s = sda_i;
    scl_oe_o = 1'b1;
    half_bit();
  endtask

  task automatic stop_cond();
    sda_oe_o = 1'b1;
    half_bit();
    release_scl();
    half_bit();
    sda_oe_o = 1'b0;
    half_bit();
  endtask
endmodule

// *** bench/usi_two_wire_tb_top.sv ***
/*
  Self-checking bench for the two-wire serial block, with an external master model.
  Assumes pull-ups on both bus lines; software controls are one-cycle pulses.
*/
`timescale 1ns/1ps
module usi_two_wire_tb_top;
  localparam int P_CNT = 0, P_DATA = 1, P_CLR = 2, P_STB = 3, P_TMR = 4;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  usi_pkg::usi_line_t line_i, line_oe_o, line_o;
  usi_pkg::usi_cfg_t cfg_i = 5'h00;
  usi_pkg::usi_flags_t flag_clr_i = 2'h0, irq_en_i = 2'h0, flags_o, irq_o;
  logic dpo = 1'b1, dpd = 1'b0, clock_strobe_i = 1'b0, timer0_ovf_i = 1'b0;
  logic data_wr_i = 1'b0, cnt_wr_i = 1'b0, wake_o, bus_busy_o, m_scl_oe, m_sda_oe, stuck, s;
  logic [7:0] data_wdata_i = 8'h00, data_o;
  logic [3:0] cnt_wdata_i = 4'h0, cnt_o;
  logic [7:0] byte_v = 8'hA5;
  logic wrap_w;
  int err_count = 0, checks_done = 0, cycles = 0, wraps = 0;

  always #5 clk_sys_i = ~clk_sys_i;
  assign line_i = {~(m_scl_oe | line_oe_o.scl), ~(m_sda_oe | line_oe_o.sda)};

  usi_two_wire usi_two_wire_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .line_i(line_i),
    .line_o(line_o), .line_oe_o(line_oe_o), .cfg_i(cfg_i), .data_pin_output_bit_i(dpo),
    .data_pin_direction_bit_i(dpd), .scl_pin_output_bit_i(1'b1),
    .scl_pin_direction_bit_i(1'b0), .clock_strobe_i(clock_strobe_i),
    .timer0_ovf_i(timer0_ovf_i), .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
    .data_o(data_o), .cnt_wr_i(cnt_wr_i), .cnt_wdata_i(cnt_wdata_i), .cnt_o(cnt_o),
    .cnt_wrap_o(wrap_w), .flag_clr_i(flag_clr_i), .irq_en_i(irq_en_i), .flags_o(flags_o),
    .irq_o(irq_o), .wake_o(wake_o), .bus_busy_o(bus_busy_o));

  usi_master_model usi_master_model_i (.clk_sys_i(clk_sys_i), .scl_i(line_i.scl),
    .sda_i(line_i.sda), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .stuck_o(stuck));

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (wrap_w === 1'b1) begin
      wraps++;
    end
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input logic [3:0] got, input logic [3:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic [1:0] c, input logic sel);
    cfg_i = {m, c, sel};
    tick(2);
  endtask

  // Controls are lowered and two more edges pass, so calls may follow back to back.
  task automatic pulse(input int k, input logic [7:0] v);
    cnt_wdata_i = v[3:0];
    data_wdata_i = v;
    cnt_wr_i = (k == P_CNT);
    data_wr_i = (k == P_DATA);
    flag_clr_i = (k == P_CLR) ? v[1:0] : 2'h0;
    clock_strobe_i = (k == P_STB);
    timer0_ovf_i = (k == P_TMR);
    tick(1);
    {cnt_wr_i, data_wr_i, flag_clr_i, clock_strobe_i, timer0_ovf_i} = 6'h00;
    tick(2);
  endtask

  initial begin
    tick(12);
    rst_n_i = 1'b1;
    tick(2);
    dpd = 1'b1;
    dpo = 1'b0;
    tick(4);
    check_bit(line_oe_o.sda, 1'b1);
    dpo = 1'b1;
    tick(4);
    check_bit(line_oe_o.sda, 1'b0);
    dpd = 1'b0;
    set_cfg(usi_pkg::MODE_THREE, usi_pkg::CS_SOFT, 1'b0);
    usi_master_model_i.start_cond();
    usi_master_model_i.stop_cond();
    check_bit(flags_o.start, 1'b0);
    set_cfg(usi_pkg::MODE_TWO, usi_pkg::CS_EXT_POS, 1'b0);
    irq_en_i.start = 1'b1;
    pulse(P_CLR, 8'h03);
    usi_master_model_i.start_cond();
    check_bit(flags_o.start, 1'b1);
    check_bit(irq_o.start, 1'b1);
    check_bit(wake_o, 1'b1);
    check_bit(bus_busy_o, 1'b1);
    check_bit(line_oe_o.scl, 1'b1);
    pulse(P_CLR, 8'h02);
    pulse(P_CNT, 8'h00);
    check_bit(line_oe_o.scl, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      usi_master_model_i.clock_bit(byte_v[i], s);
      if (i == 7) begin
        check_cnt(cnt_o, 4'h2);
      end
    end
    check_bit(flags_o.ovf, 1'b1);
    check_cnt(cnt_o, 4'h0);
    check_data(data_o, 8'hA5);
    tick(20);
    check_bit(line_oe_o.scl, 1'b1);
    dpd = 1'b1;
    pulse(P_DATA, 8'h00);
    pulse(P_CNT, 8'hE);
    pulse(P_CLR, 8'h01);
    check_bit(line_oe_o.sda, 1'b1);
    usi_master_model_i.clock_bit(1'b1, s);
    check_bit(s, 1'b0);
    check_bit(flags_o.ovf, 1'b1);
    check_bit(line_oe_o.scl, 1'b1);
    dpd = 1'b0;
    pulse(P_CLR, 8'h01);
    check_bit(line_oe_o.scl, 1'b0);
    dpd = 1'b1;
    pulse(P_DATA, 8'hFF);
    pulse(P_CNT, 8'hE);
    usi_master_model_i.clock_bit(1'b1, s);
    check_bit(s, 1'b1);
    dpd = 1'b0;
    pulse(P_CLR, 8'h01);
    usi_master_model_i.stop_cond();
    check_bit(bus_busy_o, 1'b0);
    for (int c = 2; c < 4; c++) begin
      set_cfg(usi_pkg::MODE_THREE, c[1:0], 1'b0);
      pulse(P_CLR, 8'h03);
      pulse(P_CNT, 8'h00);
      usi_master_model_i.clock_bit(1'b1, s);
      check_bit(flags_o.start, 1'b1);
      // The first pass begins with the clock line released, so only its fall is counted.
      check_cnt(cnt_o, (c == 2) ? 4'h1 : 4'h2);
    end
    set_cfg(usi_pkg::MODE_OFF, usi_pkg::CS_EXT_POS, 1'b0);
    irq_en_i.ovf = 1'b1;
    pulse(P_CLR, 8'h03);
    pulse(P_CNT, 8'hF);
    usi_master_model_i.clock_bit(1'b1, s);
    check_bit(flags_o.ovf, 1'b1);
    check_bit(irq_o.ovf, 1'b1);
    check_cnt(cnt_o, 4'h1);
    set_cfg(usi_pkg::MODE_OFF, usi_pkg::CS_SOFT, 1'b1);
    pulse(P_CLR, 8'h03);
    pulse(P_CNT, 8'hF);
    pulse(P_STB, 8'h00);
    check_bit(flags_o.ovf, 1'b1);
    check_cnt(cnt_o, 4'h0);
    irq_en_i.ovf = 1'b0;
    tick(1);
    check_bit(irq_o.ovf, 1'b0);
    set_cfg(usi_pkg::MODE_OFF, usi_pkg::CS_TIMER, 1'b0);
    pulse(P_CLR, 8'h03);
    pulse(P_CNT, 8'hE);
    pulse(P_TMR, 8'h00);
    check_cnt(cnt_o, 4'hF);
    check_bit(flags_o.ovf, 1'b0);
    pulse(P_TMR, 8'h00);
    check_bit(flags_o.ovf, 1'b1);
    check_cnt(wraps[3:0], 4'h6);
    check_cnt({2'h0, line_o}, 4'h0);
    check_bit(stuck, 1'b0);
    complete_run();
  end
endmodule

// *** common/usi_pkg.sv ***
/*
  Shared constants, carriers and mode codes for the two-wire serial interface block.
  Assumes a 100 MHz system clock; the timing counts are derived from that rate.
*/
package usi_pkg;

  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int MSB_POS = DATA_W - 1;

  // Wire mode codes; bit 1 set selects the two-wire modes.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] MODE_TWO_HOLD = 2'h3;

  // Clock source codes; bit 1 set selects the external clock pin.
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [1:0] CS_EXT_NEG = 2'h3;

  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
  localparam logic [CNT_W-1:0] CNT_ACK_PRELOAD = 4'hE;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic LATCH_RST = 1'h1;
  localparam logic [1:0] LINE_IDLE = 2'h3;

  // Data line delay ahead of start detection, least figure, rounded up.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SDA_DLY_NS = 50;
  localparam int SDA_DLY_CYC = (SDA_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic scl;
    logic sda;
  } usi_line_t;

  typedef struct packed {
    logic [1:0] wire_mode;
    logic [1:0] clock_source_select;
    logic clock_strobe_select;
  } usi_cfg_t;

  typedef struct packed {
    logic start;
    logic ovf;
  } usi_flags_t;

endpackage

// *** hdl/usi_counter.sv ***
/*
  Wrapping edge counter with a software load port and a wrap pulse.
  Assumes load and increment come from logic on clk_sys_i.
*/
`timescale 1ns/1ps
module usi_counter #(
  parameter int W = 4
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  input wire logic inc_i,
  output logic [W-1:0] cnt_o,
  output logic wrap_o
);

  logic [W-1:0] cnt_q;

  // A software load wins over a coincident count.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= load_val_i;
    end else if (inc_i) begin
      cnt_q <= W'(cnt_q + 1'b1);
    end
  end

  assign cnt_o = cnt_q;
  assign wrap_o = inc_i && !load_i && (&cnt_q);

endmodule

// *** hdl/usi_sync.sv ***
/*
  Two-flop synchroniser with edge detection on the synchronised level.
  Assumes the inputs are asynchronous to clk_sys_i and idle at RST_VAL.
*/
`timescale 1ns/1ps
module usi_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Only the second stage reads the first one.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;

endmodule

// *** hdl/usi_two_wire.sv ***
/*
  Serial interface core in two-wire mode: shift register, edge counter, start detector
  and clock line hold, with the stand-alone counter uses.
  Assumes open-drain pins resolved outside; software controls arrive as one-cycle pulses.
*/
// Function
// - Two-wire physical behaviour without slew limiting or input glitch filtering.
// - Master makes the clock in software; only the slave stretches it.
// - Every serial clock edge counts; counter wrap marks a finished transfer.
// - Data line pulled low by shift MSB zero or port bit zero.
// - Data falling while clock high sets the start flag, optional interrupt.
// - After start, clock held low from next falling edge until flag cleared.
// - Slave samples data into shift register on each rising clock edge.
// - After eight bits the counter wraps and the clock is forced low.
// - Unaddressed slave releases the clock and waits for the next start.
// - Acknowledge: data low one bit, counter preloaded with 14 first.
// - Direction bit one means slave drives data; otherwise master does.
// - Slave that cannot take more leaves the last acknowledge high.
// - Start detection only runs in two-wire mode.
// - Other modes: any clock pin edge sets flag for external counting sources.
// - Start detection can wake the core from power-down sleep.
// - Externally clocked counter counts both edges, usable stand-alone.
// - Counter cascades with the 8-bit timer to form 12 bits.
// - Counter preloaded to F wraps on one pin edge as an external interrupt.
// - A software clock strobe increments the counter, a software interrupt.
`timescale 1ns/1ps
module usi_two_wire (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input usi_pkg::usi_line_t line_i,
  output usi_pkg::usi_line_t line_o,
  output usi_pkg::usi_line_t line_oe_o,
  input usi_pkg::usi_cfg_t cfg_i,
  input wire logic data_pin_output_bit_i,
  input wire logic data_pin_direction_bit_i,
  input wire logic scl_pin_output_bit_i,
  input wire logic scl_pin_direction_bit_i,
  input wire logic clock_strobe_i,
  input wire logic timer0_ovf_i,
  input wire logic data_wr_i,
  input wire logic [usi_pkg::DATA_W-1:0] data_wdata_i,
  output logic [usi_pkg::DATA_W-1:0] data_o,
  input wire logic cnt_wr_i,
  input wire logic [usi_pkg::CNT_W-1:0] cnt_wdata_i,
  output logic [usi_pkg::CNT_W-1:0] cnt_o,
  output logic cnt_wrap_o,
  input usi_pkg::usi_flags_t flag_clr_i,
  input usi_pkg::usi_flags_t irq_en_i,
  output usi_pkg::usi_flags_t flags_o,
  output usi_pkg::usi_flags_t irq_o,
  output logic wake_o,
  output logic bus_busy_o
);

  localparam int DLY = usi_pkg::SDA_DLY_CYC;

  typedef enum logic {
    BUS_IDLE,
    BUS_BUSY
  } usi_bus_t;

  function automatic logic is_two_wire(input logic [1:0] mode);
    is_two_wire = (mode == usi_pkg::MODE_TWO) || (mode == usi_pkg::MODE_TWO_HOLD);
  endfunction

  function automatic logic is_ext_src(input logic [1:0] src);
    is_ext_src = (src == usi_pkg::CS_EXT_POS) || (src == usi_pkg::CS_EXT_NEG);
  endfunction

  usi_pkg::usi_line_t pin_q;
  usi_pkg::usi_line_t pin_rise;
  usi_pkg::usi_line_t pin_fall;
  usi_pkg::usi_line_t line_oe_q;
  logic [DLY-1:0] sda_dly_q;
  logic [usi_pkg::DATA_W-1:0] shift_q;
  logic [usi_pkg::CNT_W-1:0] cnt_q;
  logic latch_q;
  logic start_q;
  logic ovf_q;
  logic start_hold_q;
  usi_bus_t bus_q;
  logic two_wire;
  logic ext_src;
  logic pos_src;
  logic sda_fall_late;
  logic sda_rise_late;
  logic start_cond;
  logic stop_cond;
  logic edge_flag;
  logic start_set;
  logic shift_en;
  logic latch_edge;
  logic cnt_inc;
  logic cnt_wrap;
  logic scl_oe_d;
  logic sda_oe_d;

  // Pins are asynchronous; filtering is deliberately absent beyond the two flops.
  usi_sync #(
    .W(2),
    .RST_VAL(usi_pkg::LINE_IDLE)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(line_i),
    .level_o(pin_q),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign two_wire = is_two_wire(cfg_i.wire_mode);
  assign ext_src = is_ext_src(cfg_i.clock_source_select);
  assign pos_src = cfg_i.clock_source_select == usi_pkg::CS_EXT_POS;

  // The data line is delayed so the clock line is sampled after it has settled.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sda_dly_q <= '1;
    end else begin
      sda_dly_q <= {sda_dly_q[DLY-2:0], pin_q.sda};
    end
  end

  assign sda_fall_late = sda_dly_q[DLY-1] && !sda_dly_q[DLY-2];
  assign sda_rise_late = !sda_dly_q[DLY-1] && sda_dly_q[DLY-2];
  assign start_cond = two_wire && sda_fall_late && pin_q.scl;
  assign stop_cond = two_wire && sda_rise_late && pin_q.scl;

  // Outside two-wire mode, with an external source and no strobe select, the flag marks any clock pin edge instead.
  assign edge_flag = !two_wire && ext_src && !cfg_i.clock_strobe_select
                     && (pin_rise.scl || pin_fall.scl);
  assign start_set = start_cond || edge_flag;

  // Shift source: pin edge, timer overflow, or software strobe.
  always_comb begin
    shift_en = 1'b0;
    latch_edge = 1'b0;
    case (cfg_i.clock_source_select)
      usi_pkg::CS_SOFT: begin
        shift_en = cfg_i.clock_strobe_select && clock_strobe_i;
      end
      usi_pkg::CS_TIMER: begin
        shift_en = timer0_ovf_i;
      end
      usi_pkg::CS_EXT_POS: begin
        shift_en = pin_rise.scl;
        latch_edge = pin_fall.scl;
      end
      usi_pkg::CS_EXT_NEG: begin
        shift_en = pin_fall.scl;
        latch_edge = pin_rise.scl;
      end
      default: begin
        shift_en = 1'b0;
        latch_edge = 1'b0;
      end
    endcase
  end

  // Pin counting takes both edges; the timer overflow cascades into 12 bits.
  always_comb begin
    if (ext_src && cfg_i.clock_strobe_select) begin
      cnt_inc = clock_strobe_i;
    end else if (ext_src) begin
      cnt_inc = pin_rise.scl || pin_fall.scl;
    end else begin
      cnt_inc = shift_en;
    end
  end

  // Software preload, such as 14 before an acknowledge or F for an edge interrupt.
  usi_counter #(
    .W(usi_pkg::CNT_W)
  ) u_cnt (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .load_i(cnt_wr_i),
    .load_val_i(cnt_wdata_i),
    .inc_i(cnt_inc),
    .cnt_o(cnt_q),
    .wrap_o(cnt_wrap)
  );

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      shift_q <= usi_pkg::DATA_RST;
    end else if (data_wr_i) begin
      shift_q <= data_wdata_i;
    end else if (shift_en) begin
      shift_q <= {shift_q[usi_pkg::MSB_POS-1:0], pin_q.sda};
    end
  end

  // With an external clock the output latch moves on the opposite edge so the data line is stable while sampled; with the strobe or timer it moves with the shift.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      latch_q <= usi_pkg::LATCH_RST;
    end else if (data_wr_i) begin
      latch_q <= data_wdata_i[usi_pkg::MSB_POS];
    end else if (latch_edge) begin
      latch_q <= shift_q[usi_pkg::MSB_POS];
    end else if (!ext_src && shift_en) begin
      latch_q <= shift_q[usi_pkg::MSB_POS-1];
    end
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
    end else if (start_set) begin
      start_q <= 1'b1;
    end else if (flag_clr_i.start) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ovf_q <= 1'b0;
    end else if (cnt_wrap) begin
      ovf_q <= 1'b1;
    end else if (flag_clr_i.ovf) begin
      ovf_q <= 1'b0;
    end
  end

  // Start hold begins at the first falling clock edge after a start.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      start_hold_q <= 1'b0;
    end else if (!two_wire || (flag_clr_i.start && !start_set)) begin
      start_hold_q <= 1'b0;
    end else if (start_q && pin_fall.scl) begin
      start_hold_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      bus_q <= BUS_IDLE;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (start_cond) begin
            bus_q <= BUS_BUSY;
          end
        end
        BUS_BUSY: begin
          if (stop_cond || !two_wire) begin
            bus_q <= BUS_IDLE;
          end
        end
        default: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // The slave only stretches; clock edges come from the port bit as master.
  assign scl_oe_d = (two_wire && (start_hold_q || ovf_q))
                    || (scl_pin_direction_bit_i && !scl_pin_output_bit_i);
  assign sda_oe_d = data_pin_direction_bit_i
                    && (!data_pin_output_bit_i || (two_wire && !latch_q));

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      line_oe_q <= '0;
    end else begin
      line_oe_q <= {scl_oe_d, sda_oe_d};
    end
  end

  // Open-drain: the pin only ever pulls low.
  assign line_o = '0;
  assign line_oe_o = line_oe_q;
  assign data_o = shift_q;
  assign cnt_o = cnt_q;
  assign cnt_wrap_o = cnt_wrap;
  assign flags_o = {start_q, ovf_q};
  assign irq_o = {start_q && irq_en_i.start, ovf_q && irq_en_i.ovf};
  assign bus_busy_o = bus_q == BUS_BUSY;

  // A start seen on the raw pins of an idle bus wakes the core while its clock is stopped.
  // This term skips the synchroniser on purpose: it only leaves the block, no state reads it.
  assign wake_o = start_q
                  || (two_wire && bus_q == BUS_IDLE && line_i.scl && !line_i.sda);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  start_set_a: assert property (start_cond |=> start_q)
    else $error("start condition did not set the flag");

  start_mode_a: assert property (!two_wire && !edge_flag && !start_q |=> !start_q)
    else $error("start flag set outside two-wire mode");

  edge_flag_a: assert property (
    !two_wire && ext_src && !cfg_i.clock_strobe_select && pin_rise.scl |=> start_q)
    else $error("clock pin edge did not set the flag");

  cnt_step_a: assert property (
    cnt_inc && !cnt_wr_i |=> cnt_q == usi_pkg::CNT_W'($past(cnt_q) + 1'b1))
    else $error("counter did not advance by one");

  cnt_load_a: assert property (cnt_wr_i |=> cnt_q == $past(cnt_wdata_i))
    else $error("counter preload not taken");

  ovf_set_a: assert property (
    cnt_inc && !cnt_wr_i && cnt_q == usi_pkg::CNT_MAX |=> ovf_q && cnt_q == usi_pkg::CNT_RST)
    else $error("counter at maximum did not wrap into the flag");

  ovf_hold_a: assert property (two_wire && ovf_q && !flag_clr_i.ovf |=> line_oe_o.scl)
    else $error("clock not held low on overflow");

  start_hold_a: assert property (
    two_wire && start_q && pin_fall.scl && !flag_clr_i.start ##1 two_wire
    |=> line_oe_o.scl)
    else $error("clock not held after start");

  scl_free_a: assert property (
    two_wire && !ovf_q && !start_hold_q && !scl_pin_direction_bit_i |=> !line_oe_o.scl)
    else $error("clock line not released");

  shift_in_a: assert property (
    pos_src && pin_rise.scl && !data_wr_i
    |=> shift_q == {$past(shift_q[usi_pkg::MSB_POS-1:0]), $past(pin_q.sda)})
    else $error("data not shifted in on rising clock");

  sda_drive_a: assert property (
    two_wire && data_pin_direction_bit_i && !latch_q |=> line_oe_o.sda)
    else $error("data line not pulled low");

  sda_free_a: assert property (!data_pin_direction_bit_i |=> !line_oe_o.sda)
    else $error("data line driven with direction input");

  latch_edge_a: assert property (
    latch_edge && !data_wr_i |=> latch_q == $past(shift_q[usi_pkg::MSB_POS]))
    else $error("output latch missed the opposite edge");

  bus_busy_a: assert property (start_cond |=> bus_busy_o)
    else $error("bus not marked busy after start");

  start_seen_c: cover property (start_cond ##[1:200] start_hold_q);
  byte_done_c: cover property (two_wire && cnt_wrap ##1 ovf_q);
  ack_preload_c: cover property (
    cnt_wr_i && cnt_wdata_i == usi_pkg::CNT_ACK_PRELOAD ##[1:400] cnt_wrap);
  ext_irq_c: cover property (!two_wire && cnt_q == usi_pkg::CNT_MAX && cnt_wrap);

endmodule
